// file: cmm_pkg.sv
// Purpose: constants, register layout and states of the chained math block
// Assumes: percentages are unsigned, 0.01 % per step, 16 bits
// Notes:   register windows of 16 words per block, byte addressed
package cmm_pkg;
  localparam int NUM_BLK   = 4;
  localparam int NUM_IN    = 6;
  localparam int NUM_STG   = 4;
  localparam int DW        = 16;
  localparam int BLK_WORDS = 16;

  // full scale is 100.00 %
  localparam logic [15:0] PCT_FULL = 16'h2710;
  localparam logic [15:0] TRUE_MIN = 16'h0001;

  // bus address fields
  localparam int ADR_IDX_LSB = 2;
  localparam int ADR_BLK_LSB = 6;

  // word index inside a block window
  localparam logic [3:0] IDX_LIM0 = 4'h0;
  localparam logic [3:0] IDX_DEC  = 4'h6;
  localparam logic [3:0] IDX_OPS  = 4'h7;
  localparam logic [3:0] IDX_ASRC = 4'h8;
  localparam logic [3:0] IDX_ORNG = 4'h9;
  localparam logic [3:0] IDX_STAT = 4'ha;

  // field positions
  localparam int LIM_MIN_LSB = 0;
  localparam int LIM_MAX_LSB = 16;
  localparam int DEC_W       = 2;
  localparam int OPS_STRIDE  = 8;
  localparam int OP_LSB      = 0;
  localparam int BSRC_LSB    = 4;

  // reset values
  localparam logic [31:0] LIM_RST  = 32'hffff_0000;
  localparam logic [31:0] ORNG_RST = 32'h2710_0000;
  localparam logic [31:0] CFG_RST  = 32'h0000_0000;
  localparam logic [15:0] DAT_RST  = 16'h0000;

  // source codes
  localparam logic [2:0] SRC_NONE = 3'h0;
  localparam logic [2:0] SRC_LAST = 3'h6;

  // operator codes
  localparam logic [3:0] OP_EQ  = 4'h0;
  localparam logic [3:0] OP_NE  = 4'h1;
  localparam logic [3:0] OP_GT  = 4'h2;
  localparam logic [3:0] OP_GE  = 4'h3;
  localparam logic [3:0] OP_LT  = 4'h4;
  localparam logic [3:0] OP_LE  = 4'h5;
  localparam logic [3:0] OP_OR  = 4'h6;
  localparam logic [3:0] OP_AND = 4'h7;
  localparam logic [3:0] OP_XOR = 4'h8;
  localparam logic [3:0] OP_ADD = 4'h9;
  localparam logic [3:0] OP_SUB = 4'ha;
  localparam logic [3:0] OP_MUL = 4'hb;
  localparam logic [3:0] OP_DIV = 4'hc;
  localparam logic [3:0] OP_MIN = 4'hd;
  localparam logic [3:0] OP_MAX = 4'he;

  // sequence counts
  localparam logic [2:0] LAST_IN  = 3'h5;
  localparam logic [2:0] LAST_STG = 3'h3;

  typedef enum logic [1:0] {ST_NORM, ST_STAGE, ST_OUT} cmm_state_e;
endpackage

// file: cmm_math_top.sv
// Purpose: four chained math blocks with a classic Wishbone register slave
// Assumes: source values come from logic on mclk_in; ce_in freezes all state
// Notes:   one evaluation cycle is 11 enabled clocks per block
`timescale 1ns/100ps
module cmm_math_top (
  // clock, reset, enable
  input  wire logic         mclk_in,
  input  wire logic         rst_b_in,
  input  wire logic         ce_in,
  // wishbone slave
  input  wire logic         wb_cyc_in,
  input  wire logic         wb_stb_in,
  input  wire logic         wb_we_in,
  input  wire logic [7:0]   wb_adr_in,
  input  wire logic [3:0]   wb_sel_in,
  input  wire logic [31:0]  wb_dat_in,
  output logic      [31:0]  wb_dat_out,
  output logic              wb_ack_out,
  // source values, block b input i at bits (b*6+i)*16
  input  wire logic [383:0] src_val_in,
  // results and exported limits, block b at bits b*16
  output logic      [63:0]  res_val_out,
  output logic      [63:0]  res_min_out,
  output logic      [63:0]  res_max_out,
  output logic      [3:0]   res_upd_out
);

  function automatic logic [31:0] cmm_pow10(input logic [1:0] d);
    logic [31:0] p;
    p = 32'h1;
    case (d)
      2'h1:    p = 32'ha;
      2'h2:    p = 32'h64;
      2'h3:    p = 32'h3e8;
      default: p = 32'h1;
    endcase
    return p;
  endfunction

  function automatic logic [15:0] cmm_alu(input logic [3:0] op, input logic [15:0] a, input logic [15:0] b);
    logic [31:0] w;
    logic [31:0] a32;
    logic [31:0] b32;
    logic [31:0] f32;
    logic        ta;
    logic        tb;
    a32 = {16'h0, a};
    b32 = {16'h0, b};
    f32 = {16'h0, cmm_pkg::PCT_FULL};
    ta  = (a >= cmm_pkg::TRUE_MIN);
    tb  = (b >= cmm_pkg::TRUE_MIN);
    w   = 32'h0;
    case (op)
      cmm_pkg::OP_EQ:  w = {31'h0, a == b};
      cmm_pkg::OP_NE:  w = {31'h0, a != b};
      cmm_pkg::OP_GT:  w = {31'h0, a > b};
      cmm_pkg::OP_GE:  w = {31'h0, a >= b};
      cmm_pkg::OP_LT:  w = {31'h0, a < b};
      cmm_pkg::OP_LE:  w = {31'h0, a <= b};
      cmm_pkg::OP_OR:  w = {31'h0, ta | tb};
      cmm_pkg::OP_AND: w = {31'h0, ta & tb};
      cmm_pkg::OP_XOR: w = {31'h0, ta ^ tb};
      cmm_pkg::OP_ADD: w = a32 + b32;
      cmm_pkg::OP_SUB: w = (a > b) ? (a32 - b32) : 32'h0;
      cmm_pkg::OP_MUL: w = (a32 * b32) / f32;
      cmm_pkg::OP_DIV: w = (b == 16'h0) ? f32 : (a32 * f32) / b32;
      cmm_pkg::OP_MIN: w = (a < b) ? a32 : b32;
      cmm_pkg::OP_MAX: w = (a > b) ? a32 : b32;
      default:         w = 32'h0;
    endcase
    if (w > f32) begin
      w = f32;
    end
    return w[15:0];
  endfunction

  // configuration store and bus signals
  logic [31:0] cfg_r [0:63];
  logic [31:0] stat_w [0:3];
  logic        wb_ack_r;
  logic [31:0] wb_dat_r;

  wire         wb_req_w  = wb_cyc_in & wb_stb_in & ~wb_ack_r;
  wire  [1:0]  wb_blk_w  = wb_adr_in[cmm_pkg::ADR_BLK_LSB +: 2];
  wire  [3:0]  wb_idx_w  = wb_adr_in[cmm_pkg::ADR_IDX_LSB +: 4];
  wire  [5:0]  wb_word_w = {wb_blk_w, wb_idx_w};
  wire         wb_cfg_w  = (wb_idx_w <= cmm_pkg::IDX_ORNG);
  wire         wb_wr_w   = wb_req_w & wb_we_in & wb_cfg_w;
  wire  [31:0] wb_old_w  = cfg_r[wb_word_w];
  wire  [31:0] wb_mrg_w;
  wire  [31:0] wb_rd_w   = wb_cfg_w ? wb_old_w :
                           (wb_idx_w == cmm_pkg::IDX_STAT) ? stat_w[wb_blk_w] : 32'h0;

  for (genvar l = 0; l < 4; l++) begin : g_lane
    assign wb_mrg_w[l*8 +: 8] = wb_sel_in[l] ? wb_dat_in[l*8 +: 8] : wb_old_w[l*8 +: 8];
  end

  // single-cycle ack, dropped after one clock
  always_ff @(posedge mclk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      wb_ack_r <= 1'b0;
      wb_dat_r <= cmm_pkg::CFG_RST;
    end else if (ce_in) begin
      wb_ack_r <= wb_req_w;
      if (wb_req_w) begin
        wb_dat_r <= wb_rd_w;
      end
    end
  end

  always_ff @(posedge mclk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      for (int i = 0; i < 64; i++) begin
        if ((i % cmm_pkg::BLK_WORDS) < cmm_pkg::NUM_IN) begin
          cfg_r[i] <= cmm_pkg::LIM_RST;
        end else if ((i % cmm_pkg::BLK_WORDS) == int'(cmm_pkg::IDX_ORNG)) begin
          cfg_r[i] <= cmm_pkg::ORNG_RST;
        end else begin
          cfg_r[i] <= cmm_pkg::CFG_RST;
        end
      end
    end else if (ce_in && wb_wr_w) begin
      cfg_r[wb_word_w] <= wb_mrg_w;
    end
  end

  assign wb_ack_out = wb_ack_r;
  assign wb_dat_out = wb_dat_r;

  for (genvar b = 0; b < cmm_pkg::NUM_BLK; b++) begin : g_blk
    localparam int BASE = b * cmm_pkg::BLK_WORDS;
    cmm_pkg::cmm_state_e st_r;
    logic [2:0]  step_r;
    logic [15:0] pct_r [0:5];
    logic [15:0] acc_r;
    logic [15:0] res_r;
    logic [15:0] lmin_r;
    logic [15:0] lmax_r;
    logic        upd_r;

    // input normalisation for input step_r
    wire  [31:0] lim_w  = cfg_r[BASE + int'(step_r)];
    wire  [1:0]  dec_w  = cfg_r[BASE + int'(cmm_pkg::IDX_DEC)][int'(step_r) * cmm_pkg::DEC_W +: 2];
    wire  [15:0] raw_w  = src_val_in[(b * cmm_pkg::NUM_IN + int'(step_r)) * cmm_pkg::DW +: 16];
    wire  [31:0] xs_w   = {16'h0, raw_w} * cmm_pow10(dec_w);
    wire  [31:0] mn_w   = {16'h0, lim_w[cmm_pkg::LIM_MIN_LSB +: 16]};
    wire  [31:0] mx_w   = {16'h0, lim_w[cmm_pkg::LIM_MAX_LSB +: 16]};
    wire  [31:0] span_w = (mx_w > mn_w) ? (mx_w - mn_w) : 32'h1;
    wire  [31:0] quo_w  = ((xs_w - mn_w) * {16'h0, cmm_pkg::PCT_FULL}) / span_w;
    wire  [15:0] pnx_w  = (xs_w <= mn_w) ? 16'h0 :
                          (xs_w >= mx_w) ? cmm_pkg::PCT_FULL : quo_w[15:0];

    // stage operands
    wire  [7:0]  ops_w  = cfg_r[BASE + int'(cmm_pkg::IDX_OPS)][int'(step_r[1:0]) * cmm_pkg::OPS_STRIDE +: 8];
    wire  [3:0]  op_w   = ops_w[cmm_pkg::OP_LSB +: 4];
    wire  [2:0]  bsrc_w = ops_w[cmm_pkg::BSRC_LSB +: 3];
    wire  [2:0]  asrc_w = cfg_r[BASE + int'(cmm_pkg::IDX_ASRC)][2:0];
    wire         aok_w  = (asrc_w != cmm_pkg::SRC_NONE) && (asrc_w <= cmm_pkg::SRC_LAST);
    wire         bok_w  = (bsrc_w != cmm_pkg::SRC_NONE) && (bsrc_w <= cmm_pkg::SRC_LAST);
    wire  [15:0] pa_w   = aok_w ? pct_r[asrc_w - 3'h1] : 16'h0;
    wire  [15:0] pb_w   = bok_w ? pct_r[bsrc_w - 3'h1] : 16'h0;
    // later stages take the running result
    wire  [15:0] opa_w  = (step_r == 3'h0) ? pa_w : acc_r;
    wire  [15:0] stg_w  = (bsrc_w == cmm_pkg::SRC_NONE) ? opa_w : cmm_alu(op_w, opa_w, pb_w);

    wire  [31:0] orng_w = cfg_r[BASE + int'(cmm_pkg::IDX_ORNG)];
    wire  [15:0] omin_w = orng_w[15:0];
    wire  [15:0] omax_w = orng_w[31:16];
    wire         up_w   = (omax_w >= omin_w);
    wire  [15:0] dlt_w  = up_w ? (omax_w - omin_w) : (omin_w - omax_w);
    wire  [31:0] prd_w  = ({16'h0, acc_r} * {16'h0, dlt_w}) / {16'h0, cmm_pkg::PCT_FULL};
    wire  [15:0] out_w  = up_w ? (omin_w + prd_w[15:0]) : (omin_w - prd_w[15:0]);

    always_ff @(posedge mclk_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
        st_r   <= cmm_pkg::ST_NORM;
        step_r <= 3'h0;
        acc_r  <= cmm_pkg::DAT_RST;
        res_r  <= cmm_pkg::DAT_RST;
        lmin_r <= cmm_pkg::DAT_RST;
        lmax_r <= cmm_pkg::DAT_RST;
        upd_r  <= 1'b0;
        for (int i = 0; i < cmm_pkg::NUM_IN; i++) begin
          pct_r[i] <= cmm_pkg::DAT_RST;
        end
      end else if (ce_in) begin
        upd_r <= 1'b0;
        case (st_r)
          cmm_pkg::ST_NORM: begin
            pct_r[step_r] <= pnx_w;
            step_r        <= (step_r == cmm_pkg::LAST_IN) ? 3'h0 : step_r + 3'h1;
            if (step_r == cmm_pkg::LAST_IN) begin
              st_r <= cmm_pkg::ST_STAGE;
            end
          end
          cmm_pkg::ST_STAGE: begin
            acc_r  <= stg_w;
            step_r <= (step_r == cmm_pkg::LAST_STG) ? 3'h0 : step_r + 3'h1;
            if (step_r == cmm_pkg::LAST_STG) begin
              st_r <= cmm_pkg::ST_OUT;
            end
          end
          cmm_pkg::ST_OUT: begin
            res_r  <= out_w;
            lmin_r <= omin_w;
            lmax_r <= omax_w;
            upd_r  <= 1'b1;
            st_r   <= cmm_pkg::ST_NORM;
          end
          default: begin
            st_r   <= cmm_pkg::ST_NORM;
            step_r <= 3'h0;
          end
        endcase
      end
    end

    assign stat_w[b]             = {acc_r, res_r};
    assign res_val_out[b*16 +: 16] = res_r;
    assign res_min_out[b*16 +: 16] = lmin_r;
    assign res_max_out[b*16 +: 16] = lmax_r;
    assign res_upd_out[b]          = upd_r;
  end

endmodule // cmm_math_top

// file: cmm_math_monitor.sv
// Purpose: port checker for the chained math block
// Assumes: ce_in high whenever a check is meant to count
// Notes:   period and range checks watch block 0 only; hold and lockstep checks cover all four blocks
`timescale 1ns/100ps
module cmm_math_monitor (
  // clock and reset
  input wire logic        mclk_in,
  input wire logic        rst_b_in,
  input wire logic        ce_in,
  // bus
  input wire logic        wb_cyc_in,
  input wire logic        wb_stb_in,
  input wire logic [31:0] wb_dat_out,
  input wire logic        wb_ack_out,
  // results
  input wire logic [63:0] res_val_out,
  input wire logic [63:0] res_min_out,
  input wire logic [63:0] res_max_out,
  input wire logic [3:0]  res_upd_out
);
  default clocking cb @(posedge mclk_in); endclocking
  default disable iff (!rst_b_in || !ce_in);
  sequence req_new;
    wb_cyc_in && wb_stb_in && !wb_ack_out;
  endsequence
  sequence upd_gap;
    !res_upd_out[0] [*8] ##1 !res_upd_out[0] [*2] ##1 res_upd_out[0];
  endsequence
  ack_follow_a: assert property (req_new |=> wb_ack_out ##1 !wb_ack_out)
    else $error("ack not a single pulse after request");
  ack_idle_a: assert property (!(wb_cyc_in && wb_stb_in) |=> !wb_ack_out)
    else $error("ack without request");
  rdat_hold_a: assert property ($changed(wb_dat_out) |-> wb_ack_out)
    else $error("read data moved without ack");
  upd_period_a: assert property (res_upd_out[0] |=> upd_gap)
    else $error("update period not eleven clocks");
  res_hold_a: assert property ($changed(res_val_out) |-> res_upd_out != 4'h0)
    else $error("result moved between updates");
  lim_export_a: assert property ($changed({res_min_out, res_max_out}) |-> res_upd_out != 4'h0)
    else $error("exported limits moved between updates");
  lockstep_a: assert property (res_upd_out == 4'h0 || res_upd_out == 4'hf)
    else $error("blocks out of lockstep");
  out_range_a: assert property (res_upd_out[0] && res_min_out[15:0] <= res_max_out[15:0] |->
    res_val_out[15:0] inside {[res_min_out[15:0]:res_max_out[15:0]]}) else $error("result outside range");
endmodule // cmm_math_monitor
bind cmm_math_top cmm_math_monitor u_mon (.mclk_in(mclk_in), .rst_b_in(rst_b_in), .ce_in(ce_in),
  .wb_cyc_in(wb_cyc_in), .wb_stb_in(wb_stb_in), .wb_dat_out(wb_dat_out), .wb_ack_out(wb_ack_out),
  .res_val_out(res_val_out), .res_min_out(res_min_out), .res_max_out(res_max_out), .res_upd_out(res_upd_out));

// file: cmm_src_model.sv
// Purpose: upstream function blocks feeding source values
// Assumes: values change only when the bench loads one
// Notes:   registered, same clock as the block
`timescale 1ns/100ps
module cmm_src_model (
  // clock and reset
  input  wire logic         clk_in,
  input  wire logic         rst_b_in,
  // load port
  input  wire logic         ld_in,
  input  wire logic [4:0]   ld_idx_in,
  input  wire logic [15:0]  ld_val_in,
  // source values
  output logic      [383:0] src_val_out
);
  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      src_val_out <= 384'h0;
    end else if (ld_in) begin
      src_val_out[ld_idx_in*16 +: 16] <= ld_val_in;
    end
  end
endmodule // cmm_src_model

// file: tb_top.sv
// Purpose: self-checking bench for the chained math block
// Assumes: block 0 exercised in depth, other blocks for independence, ce_in held high
// Notes:   results checked after two full passes
`timescale 1ns/100ps
module tb_top;
  logic         mclk_in = 1'b0;
  logic         rst_b_in;
  logic         wb_cyc = 1'b0;
  logic         wb_stb = 1'b0;
  logic         wb_we = 1'b0;
  logic [7:0]   wb_adr = 8'h00;
  logic [1:0]   wb_blk = 2'h0;
  logic [31:0]  wb_wdat = 32'h0;
  logic [31:0]  wb_rdat;
  logic         wb_ack;
  logic         ld = 1'b0;
  logic [4:0]   ld_idx = 5'h00;
  logic [15:0]  ld_val = 16'h0000;
  logic [383:0] src_val;
  logic [63:0]  res_val;
  logic [63:0]  res_min;
  logic [63:0]  res_max;
  logic [3:0]   res_upd;
  logic [31:0]  q;
  int           errors = 0;
  int           cmp_count = 0;
  logic [15:0]  op_exp [0:14] = '{16'h0, 16'h1, 16'h0, 16'h0, 16'h1, 16'h1, 16'h1, 16'h1, 16'h0,
                                  16'h2710, 16'h0, 16'h0834, 16'h10bd, 16'h0bb8, 16'h1b58};
  always #50 mclk_in = ~mclk_in;
  cmm_math_top DUT (.mclk_in(mclk_in), .rst_b_in(rst_b_in), .ce_in(1'b1), .wb_cyc_in(wb_cyc),
    .wb_stb_in(wb_stb), .wb_we_in(wb_we), .wb_adr_in(wb_adr), .wb_sel_in(4'hf), .wb_dat_in(wb_wdat),
    .wb_dat_out(wb_rdat), .wb_ack_out(wb_ack), .src_val_in(src_val), .res_val_out(res_val),
    .res_min_out(res_min), .res_max_out(res_max), .res_upd_out(res_upd));
  cmm_src_model u_src (.clk_in(mclk_in), .rst_b_in(rst_b_in), .ld_in(ld), .ld_idx_in(ld_idx),
    .ld_val_in(ld_val), .src_val_out(src_val));
  task automatic finish_test;
    $display("errors %0d compares %0d", errors, cmp_count);
    if (errors == 0 && cmp_count > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    cmp_count++;
    if (g !== e) begin
      errors++;
      $display("[ERR] %s exp %h got %h", nm, e, g);
    end
  endtask
  task automatic wb(input logic we, input logic [3:0] idx, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge mclk_in);
    wb_cyc <= 1'b1;
    wb_stb <= 1'b1;
    wb_we <= we;
    wb_adr <= {wb_blk, idx, 2'h0};
    wb_wdat <= d;
    do begin
      @(posedge mclk_in);
      n++;
    end while (wb_ack !== 1'b1 && n < 20);
    q = wb_rdat;
    wb_cyc <= 1'b0;
    wb_stb <= 1'b0;
    if (n >= 20) begin
      errors++;
      finish_test();
    end
  endtask
  task automatic src(input logic [4:0] i, input logic [15:0] v);
    @(posedge mclk_in);
    ld <= 1'b1;
    ld_idx <= i;
    ld_val <= v;
    @(posedge mclk_in);
    ld <= 1'b0;
  endtask
  // two full passes so new config and sources are all seen
  task automatic settle;
    int n;
    repeat (2) begin
      n = 0;
      do begin
        @(posedge mclk_in);
        n++;
      end while (res_upd[0] !== 1'b1 && n < 40);
      if (n >= 40) begin
        errors++;
        finish_test();
      end
    end
  endtask
  task automatic t_regs;
    wb(1'b0, 4'h0, 32'h0);
    chk("limit reset", 32'hffff_0000, q);
    wb(1'b0, 4'h9, 32'h0);
    chk("out range reset", 32'h2710_0000, q);
    wb(1'b1, 4'hb, 32'h1234_5678);
    wb(1'b0, 4'hb, 32'h0);
    chk("unmapped word", 32'h0, q);
  endtask
  task automatic t_ops;
    logic [3:0]  lo [4] = '{4'h6, 4'h7, 4'h8, 4'hc};
    logic [15:0] le [4] = '{16'h1, 16'h0, 16'h1, 16'h2710};
    for (int i = 0; i < 3; i++) begin
      wb(1'b1, i[3:0], 32'h2710_0000);
    end
    wb(1'b1, 4'h8, 32'h1);
    src(5'h00, 16'h0bb8);
    src(5'h01, 16'h1b58);
    for (int op = 0; op < 15; op++) begin
      wb(1'b1, 4'h7, {24'h0, 4'h2, op[3:0]});
      settle();
      chk("operator result", {16'h0, op_exp[op]}, {16'h0, res_val[15:0]});
    end
    // sum past full scale must clip
    src(5'h00, 16'h1b58);
    wb(1'b1, 4'h7, {24'h0, 4'h2, 4'h9});
    settle();
    chk("saturated sum", 32'h0000_2710, {16'h0, res_val[15:0]});
    src(5'h00, 16'h0001);
    src(5'h01, 16'h0000);
    for (int k = 0; k < 4; k++) begin
      wb(1'b1, 4'h7, {24'h0, 4'h2, lo[k]});
      settle();
      chk("truth and zero divisor", {16'h0, le[k]}, {16'h0, res_val[15:0]});
    end
  endtask
  task automatic t_chain;
    src(5'h00, 16'h0bb8);
    src(5'h01, 16'h1b58);
    src(5'h02, 16'h03e8);
    wb(1'b1, 4'h7, 32'h2b1a_392d);
    settle();
    chk("chained stages", 32'h0000_02bc, {16'h0, res_val[15:0]});
  endtask
  task automatic t_scale;
    wb(1'b1, 4'h7, 32'h0);
    wb(1'b1, 4'h6, 32'h1);
    src(5'h00, 16'h012c);
    wb(1'b1, 4'h9, 32'h0bb8_03e8);
    settle();
    chk("scaled result", 32'h0000_0640, {16'h0, res_val[15:0]});
    chk("exported limits", 32'h0bb8_03e8, {res_max[15:0], res_min[15:0]});
    wb(1'b0, 4'ha, 32'h0);
    chk("status word", 32'h0bb8_0640, q);
    // max below min gives a falling scale
    wb(1'b1, 4'h9, 32'h03e8_0bb8);
    settle();
    chk("falling scale", 32'h0000_0960, {16'h0, res_val[15:0]});
    chk("falling limits", 32'h03e8_0bb8, {res_max[15:0], res_min[15:0]});
  endtask
  task automatic t_blocks;
    wb_blk = 2'h1;
    wb(1'b1, 4'h9, 32'h0456_0123);
    settle();
    wb_blk = 2'h0;
    chk("block 1 result", 32'h0000_0123, {16'h0, res_val[31:16]});
    chk("block 1 limits", 32'h0456_0123, {res_max[31:16], res_min[31:16]});
    chk("block 0 untouched", 32'h0000_0960, {16'h0, res_val[15:0]});
    chk("blocks 2 and 3", 32'h0, res_val[63:32]);
  endtask
  initial begin
    // x to low is a falling edge, so the async reset really fires
    rst_b_in <= 1'b0;
    repeat (16) @(posedge mclk_in);
    rst_b_in <= 1'b1;
    t_regs();
    t_ops();
    t_chain();
    t_scale();
    t_blocks();
    finish_test();
  end
endmodule // tb_top
